// ===== common/eep_pkg.sv
// Package with the constants, states and port bundles of the two-wire memory slave.
package eep_pkg;

  // Word and address geometry of the memory.
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 17;
  localparam int PAGE_W = 8;
  localparam int PAGE_SIZE = 256;

  // Layout of the device address word, most significant bits first.
  localparam logic [3:0] DEV_PREAMBLE = 4'ha;
  localparam int DEV_PRE_LSB = 4;
  localparam int DEV_CS_LSB = 2;
  localparam int DEV_PAGE_BIT = 1;
  localparam int DEV_RW_BIT = 0;

  // Bit counter values: byte complete after eight rises, ninth rise is the acknowledge.
  localparam logic [3:0] CNT_BYTE_DONE = 4'h8;
  localparam logic [3:0] CNT_ACK_SLOT = 4'h9;

  // Program cycle time in milliseconds and its length in system clock cycles.
  localparam int SYS_CLK_KHZ = 125000;
  localparam int PROGRAM_CYCLE_TIME_MS = 5;
  localparam int PROG_CYCLES = PROGRAM_CYCLE_TIME_MS * SYS_CLK_KHZ;
  localparam int PROG_CNT_W = 20;

  // Phases of a bus transfer as seen by the slave.
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_DEV,
    PH_ADDR_HI,
    PH_ADDR_LO,
    PH_WDATA,
    PH_RDATA
  } eep_phase_type;

  // The two chip select strap pins.
  typedef struct packed {
    logic chip_select_strap_high;
    logic chip_select_strap_low;
  } eep_strap_type;

  // Open-drain data pin drive: level and output enable.
  typedef struct packed {
    logic sda_o;
    logic sda_oe;
  } eep_sda_drive_type;

endpackage : eep_pkg

// ===== verilog/eep_two_wire_slave.sv
// Two-wire serial slave with a 128K x 8 memory array behind it.
`timescale 1ns/10ps
`default_nettype none

module eep_two_wire_slave #(
  parameter int unsigned PROG_CYCLES = eep_pkg::PROG_CYCLES
) (
  // System clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Two-wire bus: serial clock from the master and open-drain data.
  input wire logic scl_clk_i,
  input wire logic sda_i,
  output eep_pkg::eep_sda_drive_type sda_drive_o,
  // Strap and protect pins.
  input wire eep_pkg::eep_strap_type strap_i,
  input wire logic write_protect_i,
  // Status.
  output logic program_busy_o
);
  import eep_pkg::*;

  // The program timer must fit its counter and last at least one cycle.
  if (PROG_CYCLES < 1 || PROG_CYCLES > (2 ** PROG_CNT_W))
  begin : gen_bad_prog_cycles
    $error("PROG_CYCLES does not fit the program timer");
  end

  // Last value of the program timer before the cycle ends.
  localparam logic [PROG_CNT_W-1:0] PROG_CNT_LAST = PROG_CNT_W'(PROG_CYCLES - 1);

  // Whole state of the system-clock side, registered in one place.
  typedef struct packed {
    logic scl_s1;                  // First synchroniser stage of the clock pin.
    logic scl_s2;                  // Second stage, safe to read.
    logic scl_d;                   // Previous synchronised clock, for edges.
    logic sda_s1;                  // First synchroniser stage of the data pin.
    logic sda_s2;                  // Second stage, safe to read.
    logic sda_d;                   // Previous synchronised data, for edges.
    logic wp_s1;                   // Write protect, first stage.
    logic wp_s2;                   // Write protect, second stage.
    logic [1:0] cs_s1;             // Straps, first stage.
    logic [1:0] cs_s2;             // Straps, second stage.
    eep_phase_type phase;          // Transfer phase.
    logic [3:0] cnt;               // Clock rises seen in the current word.
    logic rw;                      // Operation chosen by the address word.
    logic p0;                      // Page bit held until the address is complete.
    logic [BYTE_W-1:0] addr_hi;    // High address byte held until the low byte.
    logic [ADDR_W-1:0] addr;       // Address counter, kept across transfers.
    logic [BYTE_W-1:0] txd;        // Read byte being shifted out.
    logic sda_oe;                  // Pulling the data line low.
    logic mack;                    // Master acknowledged the last read byte.
    logic [PAGE_SIZE-1:0] mask;    // Page buffer bytes written in this sequence.
    logic commit;                  // One-cycle pulse copying the page into the array.
    logic busy;                    // Program cycle running.
    logic [PROG_CNT_W-1:0] prog_cnt; // Program cycle timer.
  } eep_state_type;

  eep_state_type st;       // Registered state.
  eep_state_type next_st;  // Next state from the combinational process.

  // Storage: the array itself and the page staging buffer.
  logic [BYTE_W-1:0] mem_array [0:(2 ** ADDR_W) - 1];
  logic [BYTE_W-1:0] page_buf [0:PAGE_SIZE-1];

  // The receive shift register sits on the bus clock itself, so no data bit
  // depends on the system clock catching a short clock-high time.
  logic [BYTE_W-1:0] link_shift; // Receive shift register on the bus clock.
  logic [BYTE_W-1:0] mem_rd;     // Array byte at the address counter.
  logic pbuf_we;                 // Store the received byte in the page buffer.
  logic scl_rise;                // Synchronised clock rose.
  logic scl_fall;                // Synchronised clock fell.
  logic bus_start;               // Start condition seen.
  logic bus_stop;                // Stop condition seen.

  // Checks an address word against the preamble and the strap levels.
  // The page bit and the operation bit take no part in the match.
  function automatic logic dev_match(input logic [BYTE_W-1:0] word, input logic [1:0] cs);
    dev_match = (word[BYTE_W-1:DEV_PRE_LSB] == DEV_PREAMBLE) &&
                (word[DEV_PAGE_BIT+2:DEV_CS_LSB] == cs);
  endfunction : dev_match

  // Bus-clock domain: sample each data bit on the rising clock edge.
  // The word is read by the system side only after a synchronised fall,
  // and it then stands still until the next bus clock rise, a
  // clock-low time after the fall, so no bit is caught mid-change.
  always_ff @(posedge scl_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      link_shift <= '0;
    end
    else
    begin
      link_shift <= {link_shift[BYTE_W-2:0], sda_i};
    end
  end

  // Edges and bus conditions from the synchronised pins.
  // The data line may only move with the clock low, so any move seen
  // while the clock stays high is a start or a stop.
  // The synchronisers add two to three system clocks of delay, so the bus
  // clock must stay high and low for at least four system clocks each.
  assign scl_rise = st.scl_s2 & ~st.scl_d;
  assign scl_fall = ~st.scl_s2 & st.scl_d;
  assign bus_start = st.scl_s2 & st.scl_d & st.sda_d & ~st.sda_s2;
  assign bus_stop = st.scl_s2 & st.scl_d & ~st.sda_d & st.sda_s2;

  // Array byte at the address counter, for reads.
  assign mem_rd = mem_array[st.addr];

  // Next-state logic of the whole protocol engine.
  always_comb
  begin
    next_st = st;
    pbuf_we = 1'b0;
    // Two flip-flop synchronisers for every pin.
    next_st.scl_s1 = scl_clk_i;
    next_st.scl_s2 = st.scl_s1;
    next_st.scl_d = st.scl_s2;
    next_st.sda_s1 = sda_i;
    next_st.sda_s2 = st.sda_s1;
    next_st.sda_d = st.sda_s2;
    next_st.wp_s1 = write_protect_i;
    next_st.wp_s2 = st.wp_s1;
    next_st.cs_s1 = {strap_i.chip_select_strap_high, strap_i.chip_select_strap_low};
    next_st.cs_s2 = st.cs_s1;
    // The commit pulse lasts one cycle; the staged bytes are then spent.
    next_st.commit = 1'b0;
    if (st.commit)
    begin
      next_st.mask = '0;
    end
    // Program cycle timer; its end frees the device for polling.
    // It counts system clocks, so its length follows the system clock rate
    // that the package assumes; a faster clock needs a larger count.
    if (st.busy)
    begin
      if (st.prog_cnt == PROG_CNT_LAST)
      begin
        next_st.busy = 1'b0;
        next_st.prog_cnt = '0;
      end
      else
      begin
        next_st.prog_cnt = st.prog_cnt + 1'b1;
      end
    end
    // A start aborts any transfer under way; staged write bytes are dropped,
    // because only a stop may launch programming.
    if (bus_start)
    begin
      next_st.phase = PH_DEV;
      next_st.cnt = '0;
      next_st.sda_oe = 1'b0;
      next_st.mask = '0;
    end
    else if (bus_stop)
    begin
      // Stop returns to standby; after write data it launches programming
      // unless the array is protected, in which case the bytes are dropped.
      if ((|st.mask) && !st.wp_s2)
      begin
        next_st.commit = 1'b1;
        next_st.busy = 1'b1;
        next_st.prog_cnt = '0;
      end
      else
      begin
        next_st.mask = '0;
      end
      next_st.phase = PH_IDLE;
      next_st.sda_oe = 1'b0;
    end
    else if (st.phase != PH_IDLE)
    begin
      // Count clock rises; the ninth rise carries the acknowledge.
      if (scl_rise && (st.cnt != CNT_ACK_SLOT))
      begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt == CNT_BYTE_DONE)
        begin
          // Master acknowledge of a read byte, sampled on the rise.
          // A released line leaves this low, which ends the read at the next fall.
          next_st.mack = ~st.sda_s2;
        end
      end
      // Everything the slave drives changes just after a clock fall.
      if (scl_fall)
      begin
        if (st.cnt == CNT_BYTE_DONE)
        begin
          // A whole word is in: decide the acknowledge for the ninth clock.
          // The shift register stays still until the next bus clock rise.
          case (st.phase)
            PH_DEV:
            begin
              // A busy device stays silent, which is what polling relies on.
              if (dev_match(link_shift, st.cs_s2) && !st.busy)
              begin
                next_st.sda_oe = 1'b1;
                next_st.rw = link_shift[DEV_RW_BIT];
                // A read word's page bit is kept but unused; reads go on from the counter.
                next_st.p0 = link_shift[DEV_PAGE_BIT];
              end
              else
              begin
                next_st.phase = PH_IDLE;
              end
            end
            PH_ADDR_HI:
            begin
              next_st.addr_hi = link_shift;
              next_st.sda_oe = 1'b1;
            end
            PH_ADDR_LO:
            begin
              next_st.addr = {st.p0, st.addr_hi, link_shift};
              next_st.sda_oe = 1'b1;
            end
            PH_WDATA:
            begin
              // Stage the byte and step only the in-page part of the address.
              pbuf_we = 1'b1;
              next_st.mask[st.addr[PAGE_W-1:0]] = 1'b1;
              next_st.addr[PAGE_W-1:0] = st.addr[PAGE_W-1:0] + 1'b1;
              // Protected writes are still acknowledged; protection acts at the stop.
              next_st.sda_oe = 1'b1;
            end
            PH_RDATA:
            begin
              // Free the line for the master's acknowledge; count past the byte.
              next_st.sda_oe = 1'b0;
              next_st.addr = st.addr + 1'b1;
            end
            default:
            begin
              next_st.phase = PH_IDLE;
            end
          endcase
        end
        else if (st.cnt == CNT_ACK_SLOT)
        begin
          // Acknowledge clock over: release and move to the next word.
          // Releasing only after the fall keeps the acknowledge low all clock-high long.
          next_st.cnt = '0;
          next_st.sda_oe = 1'b0;
          case (st.phase)
            PH_DEV:
            begin
              if (st.rw)
              begin
                next_st.phase = PH_RDATA;
                next_st.txd = mem_rd;
                next_st.sda_oe = ~mem_rd[BYTE_W-1];
              end
              else
              begin
                next_st.phase = PH_ADDR_HI;
              end
            end
            PH_ADDR_HI:
            begin
              next_st.phase = PH_ADDR_LO;
            end
            PH_ADDR_LO:
            begin
              next_st.phase = PH_WDATA;
            end
            PH_WDATA:
            begin
              next_st.phase = PH_WDATA;
            end
            PH_RDATA:
            begin
              if (st.mack)
              begin
                next_st.txd = mem_rd;
                next_st.sda_oe = ~mem_rd[BYTE_W-1];
              end
              else
              begin
                next_st.phase = PH_IDLE;
              end
            end
            default:
            begin
              next_st.phase = PH_IDLE;
            end
          endcase
        end
        else if (st.phase == PH_RDATA)
        begin
          // Next read bit, most significant first; a one is a released line.
          next_st.txd = st.txd << 1;
          next_st.sda_oe = ~st.txd[BYTE_W-2];
        end
      end
    end
  end

  // State register; reset leaves the device in standby with the line free.
  // The array and the page buffer stay out of this reset on purpose: clearing
  // them would hide reads of bytes that were never written.
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Storage writes. The array has no reset, like a real nonvolatile array.
  // Bytes are staged first and copied only on commit, so an aborted or
  // protected sequence leaves the stored contents untouched.
  // A whole page is copied in one clock, which costs a wide write path but
  // keeps the program timer independent of how many bytes were staged.
  always_ff @(posedge clk_sys_i)
  begin
    if (pbuf_we)
    begin
      page_buf[st.addr[PAGE_W-1:0]] <= link_shift;
    end
    if (st.commit)
    begin
      for (int i = 0; i < PAGE_SIZE; i++)
      begin
        if (st.mask[i])
        begin
          mem_array[{st.addr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // Outputs: the pin only ever pulls low, enabled from a register.
  // Driving a high level would fight the other devices on the shared wire.
  assign sda_drive_o.sda_o = 1'b0;
  assign sda_drive_o.sda_oe = st.sda_oe;
  assign program_busy_o = st.busy;

endmodule : eep_two_wire_slave

`default_nettype wire

// ===== test/eep_bus_master.sv
// Behavioural two-wire bus master that drives the serial clock and pulls the data wire.
`timescale 1ns/10ps
`default_nettype none

module eep_bus_master (
  // Link tick clock and the resolved data wire.
  input wire logic link_clk_i,
  input wire logic sda_i,
  // Serial clock and the data pull-down enable.
  output logic scl_o,
  output logic sda_oe_o
);
  // The bus idles with both lines released high.
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // Every line change lands just after a link tick.
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk_i);
  endtask : tick

  // Start or repeated start; the first wait lets a slave release its acknowledge.
  task automatic start();
    tick(3);
    sda_oe_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_oe_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
  endtask : start

  // Stop: data rises while the clock is high.
  task automatic stop();
    tick(1);
    sda_oe_o <= 1'b1;
    tick(3);
    scl_o <= 1'b1;
    tick(4);
    sda_oe_o <= 1'b0;
    tick(4);
  endtask : stop

  // One clock pulse; data moves only while the clock is low, and is read mid-high.
  task automatic bit_io(input logic val, output logic seen);
    tick(1);
    sda_oe_o <= !val;
    tick(3);
    scl_o <= 1'b1;
    tick(2);
    seen = sda_i;
    tick(2);
    scl_o <= 1'b0;
  endtask : bit_io

  // Sends a word MSB first and returns the slave's acknowledge.
  task automatic put_byte(input logic [7:0] val, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--)
      bit_io(val[i], seen);
    bit_io(1'b1, seen);
    ack = !seen;
  endtask : put_byte

  // Reads a word; leaving out the acknowledge ends a sequential read.
  task automatic get_byte(input logic ack_in, output logic [7:0] val);
    logic seen;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, seen);
      val[i] = seen;
    end
    bit_io(!ack_in, seen);
  endtask : get_byte
endmodule : eep_bus_master
`default_nettype wire

// ===== test/eep_two_wire_slave_props.sv
// Concurrent checks on the ports of the two-wire memory slave.
`timescale 1ns/10ps
`default_nettype none

module eep_two_wire_slave_props #(
  parameter int unsigned PROG_CYCLES = eep_pkg::PROG_CYCLES
) (
  // System clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Bus lines.
  input wire logic scl_clk_i,
  input wire logic sda_i,
  input wire eep_pkg::eep_sda_drive_type sda_drive_o,
  // Straps, protect and status.
  input wire eep_pkg::eep_strap_type strap_i,
  input wire logic write_protect_i,
  input wire logic program_busy_o
);
  import eep_pkg::*;
  // Length of the current program cycle, so a short or long timer shows up at its end.
  logic [19:0] busy_cnt;
  logic [19:0] next_busy_cnt;

  // The count restarts whenever the status drops.
  always_comb next_busy_cnt = program_busy_o ? busy_cnt + 20'h0_0001 : 20'h0_0000;

  // Counter register.
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      busy_cnt <= 20'h0_0000;
    else
      busy_cnt <= next_busy_cnt;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  open_drain_a: assert property (sda_drive_o.sda_o == 1'b0)
    else $error("data pin drives a high level");
  drive_on_low_a: assert property ($changed(sda_drive_o.sda_oe) |->
    !scl_clk_i && !$past(scl_clk_i) && !$past(scl_clk_i, 2))
    else $error("data drive changed near a high clock");
  ack_width_a: assert property ($rose(sda_drive_o.sda_oe) |-> sda_drive_o.sda_oe [*8])
    else $error("low drive shorter than a clock phase");
  busy_after_stop_a: assert property ($rose(program_busy_o) |->
    scl_clk_i && sda_i && $past(scl_clk_i, 3))
    else $error("program cycle began without a stop");
  busy_length_a: assert property ($fell(program_busy_o) |-> busy_cnt == 20'(PROG_CYCLES))
    else $error("program cycle length wrong");
  busy_silent_a: assert property (program_busy_o |-> !sda_drive_o.sda_oe)
    else $error("acknowledge during program cycle");
  protect_a: assert property ($rose(program_busy_o) |-> !write_protect_i)
    else $error("program cycle while protected");
  reset_idle_a: assert property ($rose(reset_n_i) |->
    !sda_drive_o.sda_oe && !program_busy_o)
    else $error("not idle after reset");
endmodule : eep_two_wire_slave_props

bind eep_two_wire_slave eep_two_wire_slave_props #(.PROG_CYCLES(PROG_CYCLES)) props_i (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .scl_clk_i(scl_clk_i), .sda_i(sda_i),
  .sda_drive_o(sda_drive_o), .strap_i(strap_i), .write_protect_i(write_protect_i),
  .program_busy_o(program_busy_o));
`default_nettype wire

// ===== test/eep_two_wire_slave_test.sv
// Self-checking bench for the two-wire memory slave with a behavioural bus master.
`timescale 1ns/10ps
`default_nettype none

module eep_two_wire_slave_test;
  import eep_pkg::*;
  // A short program cycle keeps the run brief.
  localparam int unsigned PROG_LEN = 200;
  logic clk_sys_i = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n_i = 1'b0;
  logic wp = 1'b0;
  logic scl;
  logic m_oe;
  logic sda;
  logic busy;
  eep_sda_drive_type drv;
  eep_strap_type strap = 2'b10;
  int n_errors = 0;
  int samples_checked = 0;

  always #4 clk_sys_i = !clk_sys_i;
  always #7.5 link_clk = !link_clk;
  // Pulled-up wire: low while either party enables its pull-down.
  assign sda = !(m_oe || drv.sda_oe);

  eep_two_wire_slave #(.PROG_CYCLES(PROG_LEN)) uut (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .scl_clk_i(scl), .sda_i(sda), .sda_drive_o(drv),
    .strap_i(strap), .write_protect_i(wp), .program_busy_o(busy));
  eep_bus_master m (.link_clk_i(link_clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

  // Counts a comparison and reports a difference at once.
  task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Device word built from the strap levels of this bench.
  function automatic logic [7:0] dev(input logic p0, input logic rw);
    return {DEV_PREAMBLE, strap, p0, rw};
  endfunction : dev

  // Sends one word and folds its acknowledge into a running flag.
  task automatic send(input logic [7:0] v, inout logic all);
    logic ack;
    m.put_byte(v, ack);
    all &= ack;
  endtask : send

  // Full write: device word, both address bytes, data, stop; every word must be acknowledged.
  task automatic write_seq(input logic [16:0] a, input logic [7:0] d[$]);
    logic all;
    all = 1'b1;
    m.start();
    send(dev(a[16], 1'b0), all);
    send(a[15:8], all);
    send(a[7:0], all);
    foreach (d[i])
      send(d[i], all);
    m.stop();
    check("write acks", 17'h0_0001, {16'h0000, all});
  endtask : write_seq

  // Random read (with a dummy write) or current read; the last byte is not acknowledged.
  task automatic read_seq(input logic rnd, input logic [16:0] a, input logic [7:0] exp[$]);
    logic all;
    logic [7:0] got;
    all = 1'b1;
    if (rnd)
    begin
      m.start();
      send(dev(a[16], 1'b0), all);
      send(a[15:8], all);
      send(a[7:0], all);
    end
    m.start();
    send(dev(1'b0, 1'b1), all);
    foreach (exp[i])
    begin
      m.get_byte(i < exp.size() - 1, got);
      check("read data", {9'h000, exp[i]}, {9'h000, got});
    end
    m.stop();
    check("read acks", 17'h0_0001, {16'h0000, all});
  endtask : read_seq

  // Bounded wait for the program cycle to end.
  task automatic wait_idle();
    int n = 0;
    while (busy !== 1'b0 && n < 1000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    check("program busy", 17'h0_0000, {16'h0000, busy});
  endtask : wait_idle

  // Write at the base, then polling: refused while busy, accepted once it ends.
  task automatic t_write_poll();
    logic ack;
    write_seq(17'h0_0000, '{8'h5a, 8'ha5});
    @(negedge clk_sys_i);
    check("busy after stop", 17'h0_0001, {16'h0000, busy});
    m.start();
    m.put_byte(dev(1'b0, 1'b0), ack);
    m.stop();
    check("poll while busy", 17'h0_0000, {16'h0000, ack});
    wait_idle();
    m.start();
    m.put_byte(dev(1'b0, 1'b0), ack);
    m.stop();
    check("poll after cycle", 17'h0_0001, {16'h0000, ack});
  endtask : t_write_poll

  // Page wrap on writes, array wrap on reads, and the persistent counter.
  task automatic t_wrap_reads();
    write_seq(17'h1_fffe, '{8'h11, 8'h22, 8'h33});
    wait_idle();
    read_seq(1'b1, 17'h1_ff00, '{8'h33});
    read_seq(1'b1, 17'h1_fffe, '{8'h11, 8'h22, 8'h5a});
    read_seq(1'b0, 17'h0_0000, '{8'ha5});
  endtask : t_wrap_reads

  // Every chip select pattern and a wrong preamble under two strap settings;
  // only the strap match answers, and the usual strap setting is left in place.
  task automatic t_select();
    logic ack;
    for (int s = 0; s < 2; s++)
    begin
      @(posedge clk_sys_i);
      strap <= (s == 0) ? 2'b01 : 2'b10;
      repeat (4) @(posedge clk_sys_i);
      for (int cs = 0; cs < 4; cs++)
      begin
        m.start();
        m.put_byte({DEV_PREAMBLE, 2'(cs), 2'b00}, ack);
        m.stop();
        check("select ack", {16'h0000, 2'(cs) == strap}, {16'h0000, ack});
      end
      m.start();
      m.put_byte({4'hb, strap, 2'b00}, ack);
      m.stop();
      check("preamble ack", 17'h0_0000, {16'h0000, ack});
    end
  endtask : t_select

  // Protected write is acknowledged but starts no cycle and leaves the data.
  task automatic t_protect();
    @(posedge clk_sys_i);
    wp <= 1'b1;
    write_seq(17'h0_0000, '{8'hff});
    repeat (20) @(negedge clk_sys_i);
    check("busy when protected", 17'h0_0000, {16'h0000, busy});
    @(posedge clk_sys_i);
    wp <= 1'b0;
    read_seq(1'b1, 17'h0_0000, '{8'h5a});
  endtask : t_protect

  // A transfer cut short mid-byte, then start, nine clocks, start, stop.
  task automatic t_recover();
    logic ack;
    logic seen;
    m.start();
    m.put_byte(dev(1'b0, 1'b0), ack);
    repeat (3) m.bit_io(1'b0, seen);
    m.start();
    repeat (9) m.bit_io(1'b1, seen);
    m.start();
    m.stop();
    read_seq(1'b1, 17'h0_0001, '{8'ha5});
  endtask : t_recover

  // Prints the verdict and ends the run.
  task automatic test_done();
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // Main sequence after a four-cycle reset.
  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    t_write_poll();
    t_wrap_reads();
    t_select();
    t_protect();
    t_recover();
    test_done();
  end

  // Watchdog well beyond the roughly 70 us that the transfers take.
  initial
  begin
    #400000;
    n_errors++;
    test_done();
  end
endmodule : eep_two_wire_slave_test
`default_nettype wire
